/* File: rtl/rxs_regs.vh */
`ifndef RXS_REGS_VH
`define RXS_REGS_VH
`define RXS_ADDR_W 8
`define RXS_OFF_CTRL 8'h00
`define RXS_OFF_STAT 8'h04
`define RXS_OFF_FIFO 8'h08
`define RXS_OFF_DATA 8'h0C
`define RXS_OFF_LEVEL 8'h10
`define RXS_CTRL_RECEIVE_ENABLE_BIT 0
`define RXS_CTRL_PASSBAD 16
`define RXS_CTRL_RESET 32'h00000000
`define RXS_ST_ERRFLAG 0
`define RXS_ST_HALTED 1
`define RXS_ST_RUN 2
`define RXS_B_FILT 30
`define RXS_B_LEN_HI 29
`define RXS_B_LEN_LO 16
`define RXS_B_ES 15
`define RXS_B_BCAST 13
`define RXS_B_LENERR 12
`define RXS_B_RUNT 11
`define RXS_B_MCAST 10
`define RXS_B_LONG 7
`define RXS_B_LATE 6
`define RXS_B_TYPE 5
`define RXS_B_WDOG 4
`define RXS_B_MII 3
`define RXS_B_DRIB 2
`define RXS_B_CRC 1
`define RXS_RUNT_BYTES 14'h0040
`define RXS_MAX_BYTES 14'h05EE
`define RXS_TYPE_MIN 16'h05DC
`define RXS_HDR_BYTES 14'h000E
`define RXS_HDR_CRC_BYTES 16'h0012
`define RXS_CTRL_MASK 32'h00FF00FF
`define RXS_WDOG_BYTES 14'h0A00
`define RXS_DRIB_MII 3'h4
`define RXS_DRIB_10M 3'h3
`define RXS_DEPTH 16
`define RXS_PTR_W 4
`define RXS_CNT_W 5
`define RXS_RESP_OKAY 2'h0
`define RXS_RESP_SLVERR 2'h2
`endif

/* File: rtl/rxs_status.v */
`timescale 1ns/100ps
// Functional notes
// - Status word bits 31, 14, 9:8 and 0 always read zero.
// - Bit 30 set when the frame failed address filtering.
// - Bits 29:16 carry the received frame size in bytes.
// - Bit 15 is the OR of bits 11, 7, 6 and 1.
// - Bit 13 set for a broadcast destination.
// - Bit 12 set when actual length disagrees with the length/type field.
// - Bit 11 marks runts under 64 bytes; runts pass only with pass-bad set.
// - Bit 10 set for a multicast destination.
// - Bit 7 set above 1518 bytes; frame is never truncated for it.
// - Bit 6 set for a collision after the collision window.
// - Bit 5 set when length/type exceeds 1500; clear for runts under 14 bytes.
// - Bit 4 set when the frame is long enough to expire the watchdog.
// - Bit 3 set when receive error was seen during the frame.
// - Bit 2 marks dribble bits: 4 in MII, 3 or more at 10M, not with bit 6.
// - Bit 1 set on CRC mismatch or receive error during the frame.
// - One halted pulse once reception really stops after enable clears.
// - Error flag set on data or status underrun, or status overrun.
// - Reception continues normally after the error flag is set.
// - Status word is pushed only after all frame data is in the data FIFO.
`include "rxs_regs.vh"
module rxs_status (
  input wire clk,
  input wire rst,
  input wire frame_start,
  input wire frame_end,
  input wire [13:0] frame_bytes,
  input wire [15:0] len_type,
  input wire filter_fail,
  input wire dest_bcast,
  input wire dest_mcast,
  input wire late_coll,
  input wire rx_er,
  input wire crc_bad,
  input wire [2:0] extra_bits,
  input wire mode_10m,
  input wire data_done,
  input wire data_underrun,
  output wire rx_busy_ok,
  output reg receive_enable_bit_q,
  output reg receiver_halted_pulse_q,
  output reg receive_error_flag_q,
  input wire [7:0] s_axi_awaddr,
  input wire s_axi_awvalid,
  output wire s_axi_awready,
  input wire [31:0] s_axi_wdata,
  input wire [3:0] s_axi_wstrb,
  input wire s_axi_wvalid,
  output wire s_axi_wready,
  output reg [1:0] s_axi_bresp,
  output reg s_axi_bvalid,
  input wire s_axi_bready,
  input wire [7:0] s_axi_araddr,
  input wire s_axi_arvalid,
  output wire s_axi_arready,
  output reg [31:0] s_axi_rdata,
  output reg [1:0] s_axi_rresp,
  output reg s_axi_rvalid,
  input wire s_axi_rready
);
  localparam ST_IDLE = 2'h0;
  localparam ST_FRAME = 2'h1;
  localparam ST_WAIT = 2'h2;

  reg [1:0] state_q;
  reg [31:0] ctrl_q;
  reg in_frame_q;
  reg mii_seen_q;
  reg [31:0] word_q;
  reg word_pend_q;
  reg halted_q;
  reg [31:0] mem_q [0:`RXS_DEPTH-1];
  reg [`RXS_PTR_W-1:0] wp_q;
  reg [`RXS_PTR_W-1:0] rp_q;
  reg [`RXS_CNT_W-1:0] cnt_q;
  reg aw_q;
  reg w_q;
  reg [7:0] awa_q;
  reg [31:0] wd_q;
  reg [3:0] ws_q;

  wire runt;
  wire too_long;
  wire is_type;
  wire len_err;
  wire wdog;
  wire drib;
  wire crc_e;
  wire [31:0] word_d;
  wire push;
  wire full;
  wire deliver;
  wire wr_go;
  wire rd_go;
  wire fifo_pop;
  wire stat_under;
  wire push_ok;
  wire err_clr;
  wire fifo_empty;
  reg [31:0] ctrl_d;
  reg [1:0] bresp_d;
  reg [31:0] rdata_d;
  reg [1:0] rresp_d;

  wire [7:0] wa;
  wire [31:0] wd;
  wire [3:0] ws;
  wire receive_enable_bit;
  assign receive_enable_bit = ctrl_q[`RXS_CTRL_RECEIVE_ENABLE_BIT];
  assign rx_busy_ok = receive_enable_bit | in_frame_q;
  assign runt = frame_bytes < `RXS_RUNT_BYTES;
  assign too_long = frame_bytes > `RXS_MAX_BYTES;
  assign is_type = (len_type > `RXS_TYPE_MIN) & (frame_bytes >= `RXS_HDR_BYTES);
  // Only 802.3 length frames can carry a mismatch; payload is total less header and CRC.
  assign len_err = ~is_type & (frame_bytes >= `RXS_HDR_BYTES) &
    ({2'h0, len_type[13:0]} != ({2'h0, frame_bytes} - `RXS_HDR_CRC_BYTES));

  assign wdog = frame_bytes >= `RXS_WDOG_BYTES;
  assign drib = ~late_coll & (mode_10m ? (extra_bits >= `RXS_DRIB_10M) :
    (extra_bits == `RXS_DRIB_MII));
  assign crc_e = crc_bad | mii_seen_q | rx_er;

  // Status bits are taken from the inputs at the frame_end edge, except bits 3, 1 and 15 also count receive errors latched earlier in the frame.
  assign word_d = {1'b0,
    filter_fail,
    frame_bytes,
    runt | too_long | late_coll | crc_e,
    1'b0,
    dest_bcast,
    len_err,
    runt,
    dest_mcast,
    2'h0,
    too_long,
    late_coll,
    is_type,
    wdog,
    mii_seen_q | rx_er,
    drib,
    crc_e,
    1'b0};
  // Runts are dropped unless pass-bad is set, so they never reach the status FIFO.
  assign deliver = ~runt | ctrl_q[`RXS_CTRL_PASSBAD];
  assign full = cnt_q == `RXS_DEPTH;
  assign push = word_pend_q & data_done;
  assign push_ok = push & ~full;

  assign wa = aw_q ? awa_q : s_axi_awaddr;
  assign wd = w_q ? wd_q : s_axi_wdata;
  assign ws = w_q ? ws_q : s_axi_wstrb;

  // A second write is refused until the host has taken the response.
  assign s_axi_awready = ~aw_q & ~s_axi_bvalid;
  assign s_axi_wready = ~w_q & ~s_axi_bvalid;
  assign wr_go = (aw_q | s_axi_awvalid) & (w_q | s_axi_wvalid) & ~s_axi_bvalid;
  assign s_axi_arready = ~s_axi_rvalid;
  assign rd_go = s_axi_arvalid & ~s_axi_rvalid;
  assign fifo_empty = cnt_q == {`RXS_CNT_W{1'b0}};
  assign fifo_pop = rd_go & (s_axi_araddr == `RXS_OFF_FIFO) & ~fifo_empty;
  assign stat_under = rd_go & (s_axi_araddr == `RXS_OFF_FIFO) & fifo_empty;
  assign err_clr = wr_go & (wa == `RXS_OFF_STAT) & ws[0] & wd[`RXS_ST_ERRFLAG];

  // Frame machine: idle, receiving, then waiting for the data side to finish the frame.
  // The halted pulse fires only from idle, so a frame in flight always completes first.
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      state_q <= ST_IDLE;
      in_frame_q <= 1'b0;
      mii_seen_q <= 1'b0;
      word_q <= 32'h00000000;
      word_pend_q <= 1'b0;
      halted_q <= 1'b1;
      receive_enable_bit_q <= 1'b0;
      receiver_halted_pulse_q <= 1'b0;
    end else begin
      receive_enable_bit_q <= receive_enable_bit;
      receiver_halted_pulse_q <= 1'b0;
      case (state_q)
        ST_IDLE: begin
          if (frame_start & receive_enable_bit) begin
            state_q <= ST_FRAME;
            in_frame_q <= 1'b1;
            mii_seen_q <= 1'b0;
            halted_q <= 1'b0;
          end else if (~receive_enable_bit & ~halted_q) begin
            halted_q <= 1'b1;
            receiver_halted_pulse_q <= 1'b1;
          end else if (receive_enable_bit) begin
            halted_q <= 1'b0;
          end
        end
        ST_FRAME: begin
          if (rx_er) begin
            mii_seen_q <= 1'b1;
          end
          if (frame_end) begin
            in_frame_q <= 1'b0;
            if (deliver) begin
              word_q <= word_d;
              word_pend_q <= 1'b1;
              state_q <= ST_WAIT;
            end else begin
              state_q <= ST_IDLE;
            end
          end
        end
        ST_WAIT: begin
          if (push) begin
            word_pend_q <= 1'b0;
            state_q <= ST_IDLE;
          end
        end
        default: begin
          state_q <= ST_IDLE;
        end
      endcase
    end
  end

  // Pointers and level sit apart from the frame machine, so a pop never waits on it.
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      wp_q <= {`RXS_PTR_W{1'b0}};
      rp_q <= {`RXS_PTR_W{1'b0}};
      cnt_q <= {`RXS_CNT_W{1'b0}};
    end else begin
      // An overrun drops the word but the receiver carries on.
      if (push_ok) begin
        wp_q <= wp_q + 4'h1;
      end
      if (fifo_pop) begin
        rp_q <= rp_q + 4'h1;
      end
      if (push_ok & ~fifo_pop) begin
        cnt_q <= cnt_q + 5'h01;
      end else if (~push_ok & fifo_pop) begin
        cnt_q <= cnt_q - 5'h01;
      end
    end
  end

  // The flag is sticky; a new event beats a software clear in the same cycle.
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      receive_error_flag_q <= 1'b0;
    end else if (data_underrun | stat_under | (push & full)) begin
      receive_error_flag_q <= 1'b1;
    end else if (err_clr) begin
      receive_error_flag_q <= 1'b0;
    end
  end

  // The word store has no reset; only entries below the level are ever read.
  always @(posedge clk) begin
    if (push_ok) begin
      mem_q[wp_q] <= word_q;
    end
  end

  // Address and data may arrive in either order; each is parked until its partner comes.
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      aw_q <= 1'b0;
      w_q <= 1'b0;
      awa_q <= 8'h00;
      wd_q <= 32'h00000000;
      ws_q <= 4'h0;
    end else if (wr_go) begin
      aw_q <= 1'b0;
      w_q <= 1'b0;
    end else begin
      if (s_axi_awvalid & s_axi_awready) begin
        aw_q <= 1'b1;
        awa_q <= s_axi_awaddr;
      end
      if (s_axi_wvalid & s_axi_wready) begin
        w_q <= 1'b1;
        wd_q <= s_axi_wdata;
        ws_q <= s_axi_wstrb;
      end
    end
  end

  // Only byte lanes 0 and 2 hold control bits; the other lanes are ignored on write.
  always @* begin
    ctrl_d = ctrl_q;
    if (wr_go & (wa == `RXS_OFF_CTRL)) begin
      if (ws[0]) begin
        ctrl_d[7:0] = wd[7:0];
      end
      if (ws[2]) begin
        ctrl_d[23:16] = wd[23:16];
      end
    end
  end

  always @(posedge clk or posedge rst) begin
    if (rst) begin
      ctrl_q <= `RXS_CTRL_RESET;
    end else begin
      ctrl_q <= ctrl_d;
    end
  end

  // Unmapped writes are answered with an error and change nothing.
  always @* begin
    if (wa == `RXS_OFF_CTRL) begin
      bresp_d = `RXS_RESP_OKAY;
    end else if (wa == `RXS_OFF_STAT) begin
      bresp_d = `RXS_RESP_OKAY;
    end else begin
      bresp_d = `RXS_RESP_SLVERR;
    end
  end

  always @(posedge clk or posedge rst) begin
    if (rst) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= `RXS_RESP_OKAY;
    end else if (wr_go) begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp <= bresp_d;
    end else if (s_axi_bvalid & s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end

  // Read data is chosen here and registered below, so the bus always sees a flop.
  // An empty pop reads zero; the underrun itself is reported through the error flag.
  always @* begin
    rdata_d = 32'h00000000;
    rresp_d = `RXS_RESP_OKAY;
    if (s_axi_araddr == `RXS_OFF_CTRL) begin
      rdata_d = ctrl_q & `RXS_CTRL_MASK;
    end else if (s_axi_araddr == `RXS_OFF_STAT) begin
      rdata_d = {29'h00000000, rx_busy_ok, halted_q, receive_error_flag_q};
    end else if (s_axi_araddr == `RXS_OFF_FIFO) begin
      rdata_d = fifo_empty ? 32'h00000000 : mem_q[rp_q];
    end else if (s_axi_araddr == `RXS_OFF_LEVEL) begin
      rdata_d = {27'h0000000, cnt_q};
    end else begin
      rresp_d = `RXS_RESP_SLVERR;
    end
  end

  always @(posedge clk or posedge rst) begin
    if (rst) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h00000000;
      s_axi_rresp <= `RXS_RESP_OKAY;
    end else if (rd_go) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rdata <= rdata_d;
      s_axi_rresp <= rresp_d;
    end else if (s_axi_rvalid & s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

endmodule // rxs_status

/* File: testbench/rxs_props.sv */
`timescale 1ns/100ps
module rxs_props (
  input clk,
  input rst,
  input data_underrun,
  input receive_enable_bit_q,
  input receiver_halted_pulse_q,
  input receive_error_flag_q,
  input [7:0] s_axi_araddr,
  input s_axi_arvalid,
  input s_axi_arready,
  input [31:0] s_axi_rdata,
  input s_axi_rvalid
);
  logic [7:0] ra_q;
  wire [31:0] d = s_axi_rdata;
  wire [13:0] n = d[29:16];
  // An empty pop reads zero, so only real status words are judged.
  wire f = s_axi_rvalid && ra_q == 8'h08 && |d;
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  always @(posedge clk or posedge rst)
    if (rst) ra_q <= 8'h00;
    else if (s_axi_arvalid && s_axi_arready) ra_q <= s_axi_araddr;
  gap_zero_a: assert property (s_axi_rvalid |-> !d[31] && !d[14] && d[9:8] == 2'h0)
    else $error("reserved bits set");
  sum_err_a: assert property (f |-> d[15] == (d[11] | d[7] | d[6] | d[1]))
    else $error("summary bit wrong");
  runt_bit_a: assert property (f |-> d[11] == (n < 14'h0040))
    else $error("runt bit wrong");
  long_bit_a: assert property (f |-> d[7] == (n > 14'h05EE))
    else $error("too long bit wrong");
  drib_late_a: assert property (f |-> !(d[2] && d[6]))
    else $error("dribble with late collision");
  halt_once_a: assert property (receiver_halted_pulse_q |=> !receiver_halted_pulse_q)
    else $error("halted pulse too long");
  halt_off_a: assert property (receiver_halted_pulse_q |-> !receive_enable_bit_q)
    else $error("halted while enabled");
  undr_flag_a: assert property (data_underrun |-> ##[1:2] receive_error_flag_q)
    else $error("underrun not flagged");
endmodule // rxs_props
bind rxs_status rxs_props p (.*);

/* File: testbench/rxs_host.sv */
`timescale 1ns/100ps
module rxs_host (
  input clk,
  output logic [7:0] s_axi_awaddr,
  output logic s_axi_awvalid,
  input s_axi_awready,
  output logic [31:0] s_axi_wdata,
  output logic [3:0] s_axi_wstrb,
  output logic s_axi_wvalid,
  input s_axi_wready,
  input s_axi_bvalid,
  output logic s_axi_bready,
  output logic [7:0] s_axi_araddr,
  output logic s_axi_arvalid,
  input s_axi_arready,
  input s_axi_rvalid,
  output logic s_axi_rready
);
  initial begin
    {s_axi_awaddr, s_axi_awvalid, s_axi_wdata, s_axi_wvalid} = 0;
    {s_axi_araddr, s_axi_arvalid} = 0;
    s_axi_wstrb = 4'hF;
    // Response readies stay high, so each response is taken at its first edge.
    {s_axi_bready, s_axi_rready} = 2'h3;
  end
  // Ready is looked at on the falling edge, where it is settled for the next rising edge.
  task automatic wr(input [7:0] a, input [31:0] v);
    bit x, y;
    x = 0;
    y = 0;
    s_axi_awaddr <= a;
    s_axi_wdata <= v;
    {s_axi_awvalid, s_axi_wvalid} <= 2'h3;
    while (!(x && y)) begin
      @(negedge clk);
      x = x | s_axi_awready;
      y = y | s_axi_wready;
      @(posedge clk);
      if (x) s_axi_awvalid <= 0;
      if (y) s_axi_wvalid <= 0;
    end
    do begin
      @(negedge clk);
      x = s_axi_bvalid;
      @(posedge clk);
    end while (!x);
  endtask
  task automatic rd(input [7:0] a);
    bit x;
    s_axi_araddr <= a;
    s_axi_arvalid <= 1;
    do begin
      @(negedge clk);
      x = s_axi_arready;
      @(posedge clk);
    end while (!x);
    s_axi_arvalid <= 0;
    do begin
      @(negedge clk);
      x = s_axi_rvalid;
      @(posedge clk);
    end while (!x);
  endtask
endmodule // rxs_host

/* File: testbench/tb_top.sv */
`timescale 1ns/100ps
module tb_top;
  logic clk = 0, rst = 1, frame_start = 0, frame_end = 0, filter_fail = 0, dest_bcast = 0;
  logic dest_mcast = 0, late_coll = 0, rx_er = 0, crc_bad = 0, mode_10m = 0, data_done = 0;
  logic data_underrun = 0;
  logic [13:0] frame_bytes = 0;
  logic [15:0] len_type = 0;
  logic [2:0] extra_bits = 0;
  wire rx_busy_ok, receive_enable_bit_q, receiver_halted_pulse_q, receive_error_flag_q;
  wire [7:0] s_axi_awaddr, s_axi_araddr;
  wire [31:0] s_axi_wdata, s_axi_rdata;
  wire [3:0] s_axi_wstrb;
  wire [1:0] s_axi_bresp, s_axi_rresp;
  wire s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
  wire s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
  logic [33:0] q[$];
  logic [31:0] w[$];
  logic [1:0] bq[$];
  int failures = 0, n_compared = 0, hc = 0;
  rxs_status dut (.*);
  rxs_host host (.*);
  always #2 clk = ~clk;
  task chk(input string n, input [33:0] s, input [33:0] e);
    n_compared++;
    if (s !== e) begin
      failures++;
      $display("ERROR %s exp %h got %h", n, e, s);
    end
  endtask
  task summarize;
    $display("compared %0d failures %0d", n_compared, failures);
    if (failures == 0 && n_compared > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  always @(negedge clk) if (s_axi_rvalid && s_axi_rready) chk("rd", {s_axi_rresp, s_axi_rdata}, q.pop_front());
  always @(negedge clk) if (s_axi_bvalid && s_axi_bready) chk("wr", 34'(s_axi_bresp), 34'(bq.pop_front()));
  always @(negedge clk) hc += receiver_halted_pulse_q;
  task rd(input [7:0] a, input [33:0] e);
    q.push_back(e);
    host.rd(a);
  endtask
  task wr(input [7:0] a, input [31:0] v, input [1:0] e);
    bq.push_back(e);
    host.wr(a, v);
  endtask
  function [31:0] ew(input [13:0] b, input [15:0] t, input [6:0] f, input [2:0] x);
    ew = 0;
    ew[30] = f[5];
    ew[29:16] = b;
    ew[13] = f[3];
    ew[12] = b >= 14'h000E && t <= 16'h05DC && t != b - 14'h0012;
    ew[11] = b < 14'h0040;
    ew[10] = f[4];
    ew[7] = b > 14'h05EE;
    ew[6] = f[2];
    ew[5] = b >= 14'h000E && t > 16'h05DC;
    ew[4] = b >= 14'h0A00;
    ew[3] = f[0];
    ew[2] = !f[2] && (f[6] ? x >= 3'h3 : x == 3'h4);
    ew[1] = f[1] | f[0];
    ew[15] = ew[11] | ew[7] | ew[6] | ew[1];
  endfunction
  task fr(input [13:0] b, input [15:0] t, input [6:0] f, input [2:0] x);
    frame_start <= 1;
    @(posedge clk) frame_start <= 0;
    rx_er <= f[0];
    @(posedge clk) rx_er <= 0;
    {mode_10m, filter_fail, dest_mcast, dest_bcast, late_coll, crc_bad} <= f[6:1];
    {frame_end, frame_bytes, len_type, extra_bits} <= {1'b1, b, t, x};
    @(posedge clk) frame_end <= 0;
    data_done <= 1;
    @(posedge clk) data_done <= 0;
  endtask
  initial begin
    logic [13:0] b;
    logic [15:0] t;
    logic [6:0] f;
    logic [2:0] x;
    void'($urandom(78));
    repeat (5) @(posedge clk);
    rst <= 0;
    @(posedge clk);
    wr(8'h00, 32'h1, 2'h0);
    rd(8'h00, 34'h1);
    rd(8'h08, 34'h0);
    rd(8'h04, 34'h5);
    rd(8'h20, {2'h2, 32'h0});
    wr(8'h20, 32'h0, 2'h2);
    wr(8'h04, 32'h1, 2'h0);
    data_underrun <= 1;
    @(posedge clk) data_underrun <= 0;
    rd(8'h04, 34'h5);
    rst <= 1;
    @(posedge clk) rst <= 0;
    @(posedge clk);
    rd(8'h04, 34'h2);
    wr(8'h00, 32'h10001, 2'h0);
    for (int i = 0; i < 18; i++) begin
      b = i == 0 ? 14'h000A : i == 1 ? 14'h05EF : i == 2 ? 14'h0A00 : 14'h0040 + 14'($urandom % 3000);
      t = $urandom % 2 ? 16'(b - 14'h0012) : 16'($urandom % 2000);
      f = 7'($urandom);
      x = 3'($urandom);
      fr(b, t, f, x);
      if (i < 16) w.push_back(ew(b, t, f, x));
    end
    rd(8'h10, 34'h10);
    rd(8'h04, 34'h5);
    repeat (16) rd(8'h08, {2'h0, w.pop_front()});
    wr(8'h00, 32'h1, 2'h0);
    fr(14'h0020, 16'h0000, 7'h00, 3'h0);
    fr(14'h0100, 16'h0800, 7'h08, 3'h0);
    rd(8'h08, {2'h0, ew(14'h0100, 16'h0800, 7'h08, 3'h0)});
    rd(8'h10, 34'h0);
    wr(8'h00, 32'h0, 2'h0);
    repeat (8) @(posedge clk);
    chk("halt", 34'(hc), 34'h1);
    chk("en", 34'(receive_enable_bit_q), 34'h0);
    chk("err", 34'(receive_error_flag_q), 34'h1);
    fr(14'h0100, 16'h0800, 7'h00, 3'h0);
    rd(8'h04, 34'h3);
    rd(8'h10, 34'h0);
    wr(8'h00, 32'h1, 2'h0);
    fr(14'h0200, 16'h05DD, 7'h10, 3'h4);
    rd(8'h08, {2'h0, ew(14'h0200, 16'h05DD, 7'h10, 3'h4)});
    summarize();
  end
  initial begin
    #40000;
    failures++;
    summarize();
  end
endmodule // tb_top
